//--- src/pio_pkg.sv
/*
  Package for the shared-pin parallel I/O port: register offsets, field
  widths, reset values and the packed structs that carry the pin-side and
  peripheral-side signal groups.
  Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
// Overview of operation
// [RULE1] Active peripheral owns pin; port driver off.
// [RULE2] Enabled idle peripheral lets port drive pin.
// [RULE3] Port output never loops into peripheral input.
// [RULE4] Direction bit one is input, zero output.
// [RULE5] Reset makes every pin an input.
// [RULE6] Latch register reads and writes the latch.
// [RULE7] Pin level read gives pins; write sets latch.
// [RULE8] Unimplemented bits read as zero everywhere.
// [RULE9] Open-drain pins only pull low; a driving peripheral that owns an open-drain pin still drives it high.
// [RULE10] Software sets analog and direction for analog.
// [RULE11] Analog select resets to all ones.
// [RULE12] Digital output still drives analog-selected pin.
// [RULE13] Analog pins read low from pin level; the code zeroes only analog pins whose direction bit is one (input).
// [RULE14] Software waits one cycle before reading back.
// [RULE15] Input-only sharing pins are plain port pins.
// [RULE16] Pin inputs synchronised, one-cycle read latency; a pin change reaches read data three edges late.
package pio_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int PORT_WIDTH = 16;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFS_DIRECTION  = 8'h00;
  localparam logic [7:0] OFS_PIN_LEVEL  = 8'h04;
  localparam logic [7:0] OFS_LATCH      = 8'h08;
  localparam logic [7:0] OFS_OPEN_DRAIN = 8'h0C;
  localparam logic [7:0] OFS_ANALOG     = 8'h10;
  localparam logic [7:0] OFS_IMPL_MASK  = 8'h14;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [PORT_WIDTH-1:0] RST_DIRECTION  = 16'hFFFF;
  localparam logic [PORT_WIDTH-1:0] RST_LATCH      = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] RST_OPEN_DRAIN = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] RST_ANALOG     = 16'hFFFF;

  // ==========================================================================
  // AXI responses
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-pin peripheral requests, one bit per pin.
  typedef struct packed {
    logic [PORT_WIDTH-1:0] enabled;
    logic [PORT_WIDTH-1:0] drive;
    logic [PORT_WIDTH-1:0] data;
  } periph_req_t;

  // Pad drive controls, one bit per pin.
  typedef struct packed {
    logic [PORT_WIDTH-1:0] out;
    logic [PORT_WIDTH-1:0] oe;
  } pad_drive_t;

endpackage

//--- src/pio_sync.sv
/*
  Two-stage synchroniser for a vector of pin levels.
  Assumes the inputs are asynchronous to the clock; bits are treated alone.
*/
`timescale 1ns/1ps
`default_nettype none
module pio_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  // Data.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // The first stage is read only by the second, to contain metastability.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;

endmodule
`default_nettype wire

//--- src/pio_pad_mux.sv
/*
  Combinational output ownership multiplexer for each shared pin.
  Assumes the port settings are already masked to implemented bits.
*/
`timescale 1ns/1ps
`default_nettype none
module pio_pad_mux #(
  parameter int WIDTH = 16
) (
  // Peripheral side.
  input  wire logic [WIDTH-1:0] periph_en_in,
  input  wire logic [WIDTH-1:0] periph_drive_in,
  input  wire logic [WIDTH-1:0] periph_data_in,
  // Port side.
  input  wire logic [WIDTH-1:0] direction_in,
  input  wire logic [WIDTH-1:0] latch_in,
  input  wire logic [WIDTH-1:0] open_drain_in,
  // Pad side.
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe_out,
  output logic      [WIDTH-1:0] periph_owns_out
);

  // Per-pin selection; a peripheral that only listens never owns the pin.
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    wire owns      = periph_en_in[i] & periph_drive_in[i]; // see [RULE1] see [RULE15]
    wire port_data = latch_in[i];
    wire port_oe   = ~direction_in[i]; // see [RULE4] see [RULE2] see [RULE12]
    wire port_od_oe = port_oe & (open_drain_in[i] ? ~port_data : 1'b1); // see [RULE9]
    assign periph_owns_out[i] = owns;
    assign pad_out[i]    = owns ? periph_data_in[i] : (open_drain_in[i] ? 1'b0 : port_data);
    assign pad_oe_out[i] = owns ? 1'b1 : port_od_oe;
  end

endmodule
`default_nettype wire

//--- src/pio_port.sv
/*
  Shared-pin parallel I/O port with an AXI4-Lite register slave.
  Holds direction, latch, open-drain and analog-select bits per pin, hands
  pin ownership to active peripherals and reads pins through a synchroniser.
  Assumes a single 40 MHz clock and asynchronous pin inputs.
*/
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pio_port #(
  parameter int                                    WIDTH     = pio_pkg::PORT_WIDTH,
  parameter logic [pio_pkg::PORT_WIDTH-1:0]        IMPL_MASK = 16'hFFFF
) (
  // Clock and reset.
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_n_in,
  // AXI4-Lite write address.
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [7:0]                s_axi_awaddr_in,
  // AXI4-Lite write data.
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  // AXI4-Lite write response.
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  output logic [1:0]                     s_axi_bresp_out,
  // AXI4-Lite read address.
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  input  wire logic [7:0]                s_axi_araddr_in,
  // AXI4-Lite read data.
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  output logic [31:0]                    s_axi_rdata_out,
  output logic [1:0]                     s_axi_rresp_out,
  // Peripheral side.
  input  wire pio_pkg::periph_req_t      periph_in,
  output logic [WIDTH-1:0]               periph_rx_out,
  // Pads.
  input  wire logic [WIDTH-1:0]          pad_in,
  output pio_pkg::pad_drive_t            pad_out
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [WIDTH-1:0] pin_direction_bits_ff;
  logic [WIDTH-1:0] output_latch_bits_ff;
  logic [WIDTH-1:0] open_drain_select_bits_ff;
  logic [WIDTH-1:0] analog_select_bits_ff;
  logic             aw_got_ff;
  logic             w_got_ff;
  logic [7:0]       aw_addr_ff;
  logic [31:0]      w_data_ff;
  logic [3:0]       w_strb_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;
  logic [WIDTH-1:0] pad_o_ff;
  logic [WIDTH-1:0] pad_oe_ff;
  logic [WIDTH-1:0] periph_rx_ff;

  // ==========================================================================
  // Pin input path
  // ==========================================================================
  wire [WIDTH-1:0] pin_sync;

  pio_sync #(.WIDTH(WIDTH)) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (pad_in),
    .sync_out   (pin_sync) // see [RULE16]
  );

  // Implemented-bit masking and analog zeroing of the pin level view.
  wire [WIDTH-1:0] dir_m   = pin_direction_bits_ff & IMPL_MASK; // see [RULE8]
  wire [WIDTH-1:0] latch_m = output_latch_bits_ff & IMPL_MASK;
  wire [WIDTH-1:0] od_m    = open_drain_select_bits_ff & IMPL_MASK;
  wire [WIDTH-1:0] ana_m   = analog_select_bits_ff & IMPL_MASK;
  wire [WIDTH-1:0] analog_in_pin = ana_m & dir_m;
  wire [WIDTH-1:0] level_view = pin_sync & IMPL_MASK & ~analog_in_pin; // see [RULE13] see [RULE7]

  // ==========================================================================
  // Output ownership
  // ==========================================================================
  wire [WIDTH-1:0] mux_o;
  wire [WIDTH-1:0] mux_oe;
  wire [WIDTH-1:0] owns;

  pio_pad_mux #(.WIDTH(WIDTH)) u_mux (
    .periph_en_in    (periph_in.enabled & IMPL_MASK),
    .periph_drive_in (periph_in.drive),
    .periph_data_in  (periph_in.data),
    .direction_in    (dir_m | ~IMPL_MASK),
    .latch_in        (latch_m),
    .open_drain_in   (od_m),
    .pad_out         (mux_o),
    .pad_oe_out      (mux_oe),
    .periph_owns_out (owns)
  );

  // Peripheral input sees the pin only when the port is not driving it,
  // so the port latch can never loop through into a peripheral.
  wire [WIDTH-1:0] port_drives = mux_oe & ~owns;
  wire [WIDTH-1:0] nxt_periph_rx = pin_sync & ~port_drives & ~ana_m; // see [RULE3]

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  wire aw_hs = s_axi_awvalid_in & s_axi_awready_out;
  wire w_hs  = s_axi_wvalid_in & s_axi_wready_out;
  wire ar_hs = s_axi_arvalid_in & s_axi_arready_out;
  wire aw_have = aw_got_ff | aw_hs;
  wire w_have  = w_got_ff | w_hs;
  wire [7:0]  wr_addr = aw_got_ff ? aw_addr_ff : s_axi_awaddr_in;
  wire [31:0] wr_data = w_got_ff ? w_data_ff : s_axi_wdata_in;
  wire [3:0]  wr_strb = w_got_ff ? w_strb_ff : s_axi_wstrb_in;
  wire do_write = aw_have & w_have & ~bvalid_ff;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == pio_pkg::OFS_DIRECTION) | (a == pio_pkg::OFS_PIN_LEVEL) |
             (a == pio_pkg::OFS_LATCH) | (a == pio_pkg::OFS_OPEN_DRAIN) |
             (a == pio_pkg::OFS_ANALOG) | (a == pio_pkg::OFS_IMPL_MASK);
  endfunction

  // Byte-lane merge of a 16-bit register; upper lanes are ignored.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  wire wr_dir   = do_write & (wr_addr == pio_pkg::OFS_DIRECTION);
  wire wr_latch = do_write & ((wr_addr == pio_pkg::OFS_LATCH) |
                              (wr_addr == pio_pkg::OFS_PIN_LEVEL)); // see [RULE6] see [RULE7]
  wire wr_od    = do_write & (wr_addr == pio_pkg::OFS_OPEN_DRAIN);
  wire wr_ana   = do_write & (wr_addr == pio_pkg::OFS_ANALOG);

  wire [WIDTH-1:0] nxt_dir   = wr_dir ? merge(pin_direction_bits_ff, wr_data, wr_strb)
                                      : pin_direction_bits_ff; // see [RULE4]
  wire [WIDTH-1:0] nxt_latch = wr_latch ? merge(output_latch_bits_ff, wr_data, wr_strb)
                                        : output_latch_bits_ff;
  wire [WIDTH-1:0] nxt_od    = wr_od ? merge(open_drain_select_bits_ff, wr_data, wr_strb)
                                     : open_drain_select_bits_ff;
  wire [WIDTH-1:0] nxt_ana   = wr_ana ? merge(analog_select_bits_ff, wr_data, wr_strb)
                                      : analog_select_bits_ff;

  // Read data select; the latch view reads the latch, never the pins.
  wire [15:0] rd_sel =
    (s_axi_araddr_in == pio_pkg::OFS_DIRECTION)  ? dir_m :
    (s_axi_araddr_in == pio_pkg::OFS_PIN_LEVEL)  ? level_view :
    (s_axi_araddr_in == pio_pkg::OFS_LATCH)      ? latch_m : // see [RULE6] see [RULE8]
    (s_axi_araddr_in == pio_pkg::OFS_OPEN_DRAIN) ? od_m :
    (s_axi_araddr_in == pio_pkg::OFS_ANALOG)     ? ana_m :
    (s_axi_araddr_in == pio_pkg::OFS_IMPL_MASK)  ? IMPL_MASK : 16'h0000;
  wire [1:0] rd_resp = mapped(s_axi_araddr_in) ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
  wire [1:0] wr_resp = mapped(wr_addr) ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;

  assign s_axi_awready_out = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready_out  = ~w_got_ff & ~bvalid_ff;
  assign s_axi_arready_out = ~rvalid_ff;

  // ==========================================================================
  // Port configuration registers
  // ==========================================================================
  // Reset leaves every pin an input and every analog pin analog.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_direction_bits_ff     <= pio_pkg::RST_DIRECTION; // see [RULE5]
      output_latch_bits_ff      <= pio_pkg::RST_LATCH;
      open_drain_select_bits_ff <= pio_pkg::RST_OPEN_DRAIN;
      analog_select_bits_ff     <= pio_pkg::RST_ANALOG; // see [RULE11]
    end else begin
      pin_direction_bits_ff     <= nxt_dir;
      output_latch_bits_ff      <= nxt_latch;
      open_drain_select_bits_ff <= nxt_od;
      analog_select_bits_ff     <= nxt_ana;
    end
  end

  // ==========================================================================
  // Write channel handshake
  // ==========================================================================
  // Address and data are held until both have arrived, in either order.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= pio_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_addr_ff <= s_axi_awaddr_in;
      end
      if (w_hs) begin
        w_data_ff <= s_axi_wdata_in;
        w_strb_ff <= s_axi_wstrb_in;
      end
      aw_got_ff <= do_write ? 1'b0 : aw_have;
      w_got_ff  <= do_write ? 1'b0 : w_have;
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_resp;
      end else if (s_axi_bready_in) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  // Read data is registered, so a pin change shows three edges late.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= pio_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {16'h0000, rd_sel};
      rresp_ff  <= rd_resp;
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Pad and peripheral outputs
  // ==========================================================================
  // Pads are registered so outputs come from flip-flops; costs one cycle.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_o_ff     <= '0;
      pad_oe_ff    <= '0;
      periph_rx_ff <= '0;
    end else begin
      pad_o_ff     <= mux_o & IMPL_MASK;
      pad_oe_ff    <= mux_oe & IMPL_MASK; // see [RULE1] see [RULE2] see [RULE12]
      periph_rx_ff <= nxt_periph_rx;
    end
  end

  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out  = bresp_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out  = rdata_ff;
  assign s_axi_rresp_out  = rresp_ff;
  assign pad_out.out      = pad_o_ff;
  assign pad_out.oe       = pad_oe_ff;
  assign periph_rx_out    = periph_rx_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_reset_inputs: assert property (@(posedge ref_clk_in) // see [RULE5]
    $rose(reset_n_in) |-> pin_direction_bits_ff == pio_pkg::RST_DIRECTION)
    else $error("direction not all inputs after reset");
  a_analog_reset: assert property (@(posedge ref_clk_in) // see [RULE11]
    $rose(reset_n_in) |-> analog_select_bits_ff == pio_pkg::RST_ANALOG)
    else $error("analog select not all ones after reset");
  a_unimpl_quiet: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE8]
    ((pad_oe_ff | pad_o_ff | rdata_ff[WIDTH-1:0]) & ~IMPL_MASK) == '0)
    else $error("unimplemented pin bit not zero");
  a_analog_drive: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE12]
    (analog_select_bits_ff[0] & !pin_direction_bits_ff[0] & !open_drain_select_bits_ff[0]
     & !periph_in.drive[0] & IMPL_MASK[0])
    |=> pad_oe_ff[0] && pad_o_ff[0] == $past(output_latch_bits_ff[0]))
    else $error("analog output pin not driven");
  a_pin_latency: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE16]
    (ar_hs && s_axi_araddr_in == pio_pkg::OFS_PIN_LEVEL && !analog_in_pin[1] && IMPL_MASK[1])
    |=> rdata_ff[1] == $past(pad_in[1], 3))
    else $error("pin level read latency wrong");
  a_periph_owns: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE1]
    (periph_in.enabled[0] & periph_in.drive[0] & IMPL_MASK[0]) |=>
    pad_oe_ff[0] && pad_o_ff[0] == $past(periph_in.data[0]))
    else $error("peripheral lost ownership of pin");
  a_port_drives: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE2]
    (!periph_in.drive[0] & !pin_direction_bits_ff[0] & !open_drain_select_bits_ff[0]
     & IMPL_MASK[0]) |=> pad_oe_ff[0] && pad_o_ff[0] == $past(output_latch_bits_ff[0]))
    else $error("port did not drive its output pin");
  a_no_loop: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE3]
    port_drives[0] |=> !periph_rx_ff[0])
    else $error("port output looped into peripheral");
  a_input_hiz: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE4]
    (pin_direction_bits_ff[0] & !periph_in.drive[0]) |=> !pad_oe_ff[0])
    else $error("input pin driven by port");
  a_open_drain: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE9]
    (open_drain_select_bits_ff[0] & output_latch_bits_ff[0] & !periph_in.drive[0])
    |=> !pad_oe_ff[0])
    else $error("open-drain pin driven high");
  a_analog_low: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE13]
    (ar_hs && s_axi_araddr_in == pio_pkg::OFS_PIN_LEVEL && analog_in_pin[0])
    |=> rvalid_ff && !rdata_ff[0])
    else $error("analog pin read as high");
  a_latch_write: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // see [RULE7]
    (do_write && wr_addr == pio_pkg::OFS_PIN_LEVEL && wr_strb[0])
    |=> output_latch_bits_ff[7:0] == $past(wr_data[7:0]))
    else $error("pin level write missed the latch");

endmodule
`default_nettype wire

//--- tb/pio_pin_model.sv
/*
  Far-side model of the pins: resolves each pad from the port's drive,
  an external source and a weak pull-up.
  Assumes every pin carries a pull-up, as open-drain use needs one.
*/
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model (
  // Port drive.
  input  wire pio_pkg::pad_drive_t drive_in,
  // External source.
  input  wire logic [15:0]         ext_en_in,
  input  wire logic [15:0]         ext_val_in,
  // Pin levels.
  output logic      [15:0]         level_out
);
  // ==========================================================================
  // Pin resolution
  // ==========================================================================
  // A released pin floats to the pull-up, never to its last driven value.
  assign level_out = (drive_in.oe & drive_in.out) | (~drive_in.oe & ext_en_in & ext_val_in)
                   | (~drive_in.oe & ~ext_en_in);
endmodule
`default_nettype wire

//--- tb/test_pio_port.sv
/*
  Self-checking bench for the parallel I/O port over AXI4-Lite.
  Assumes the pin model resolves the pads; bit 15 is left unimplemented.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pio_port;
  localparam logic [15:0] M = 16'h7FFF; // Implemented pins.
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000, level, periph_rx;
  pio_pkg::periph_req_t periph = '0;
  pio_pkg::pad_drive_t pad;
  int fails = 0, n_compared = 0, cycles = 0;

  // ==========================================================================
  // Design and far side
  // ==========================================================================
  pio_port #(.IMPL_MASK(M)) u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .periph_in(periph),
    .periph_rx_out(periph_rx), .pad_in(level), .pad_out(pad));
  pio_pin_model u_pins (.drive_in(pad), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(level));

  // Clock, and a cycle ceiling so that a hung handshake still ends the run.
  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  // Ready is sampled at the falling edge; it cannot change before the next rise.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    bit pa, pw, ta, tw;
    @(posedge ref_clk_in);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {16'h0000, d};
    bready  <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge ref_clk_in);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge ref_clk_in);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge ref_clk_in); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge ref_clk_in);
    bready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge ref_clk_in);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(negedge ref_clk_in); while (!arready);
    @(posedge ref_clk_in);
    arvalid <= 1'b0;
    do @(negedge ref_clk_in); while (!rvalid);
    chk(rdata, {16'h0000, e});
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge ref_clk_in);
    rready <= 1'b0;
  endtask

  // Lets pad updates, the synchroniser and the read register settle.
  task automatic settle();
    repeat (6) @(posedge ref_clk_in);
  endtask

  task automatic chk_pad(input logic [15:0] oe, input logic [15:0] out);
    chk({16'h0000, pad.oe & M}, {16'h0000, oe & M});
    chk({16'h0000, pad.out & oe & M}, {16'h0000, out & oe & M});
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    chk_pad(16'h0000, 16'h0000);
    rdc(8'h00, 16'hFFFF & M, 2'h0);
    rdc(8'h10, 16'hFFFF & M, 2'h0);
    rdc(8'h08, 16'h0000, 2'h0);
    rdc(8'h14, M, 2'h0);
    rdc(8'h18, 16'h0000, 2'h2);
    wr(8'h18, 16'hFFFF, 2'h2);
  endtask

  // The last write uses the upper byte lane only, so the low byte must survive.
  task automatic t_latch_pin();
    wr(8'h10, 16'h0000, 2'h0);
    wr(8'h00, 16'h0000, 2'h0);
    wr(8'h04, 16'hA5C3, 2'h0);
    settle();
    rdc(8'h08, 16'hA5C3 & M, 2'h0);
    chk_pad(16'hFFFF, 16'hA5C3);
    wr(8'h08, 16'h1234, 2'h0);
    settle();
    rdc(8'h04, 16'h1234 & M, 2'h0);
    wstrb <= 4'h2;
    wr(8'h08, 16'h56FF, 2'h0);
    wstrb <= 4'hF;
    rdc(8'h08, 16'h5634 & M, 2'h0);
  endtask

  task automatic t_input();
    wr(8'h00, 16'hFFFF, 2'h0);
    ext_en <= 16'hFFFF;
    ext_val <= 16'hDAA5;
    settle();
    chk_pad(16'h0000, 16'h0000);
    rdc(8'h04, 16'hDAA5 & M, 2'h0);
    wr(8'h10, 16'h00FF, 2'h0);
    settle();
    rdc(8'h04, 16'h5A00, 2'h0);
    chk({16'h0000, periph_rx & 16'h7F00}, {16'h0000, 16'h5A00});
  endtask

  task automatic t_analog_out();
    wr(8'h08, 16'h0F0F, 2'h0);
    wr(8'h00, 16'h0000, 2'h0);
    settle();
    chk_pad(16'hFFFF, 16'h0F0F);
    chk({16'h0000, periph_rx & M}, 32'h0);
  endtask

  task automatic t_open_drain();
    ext_en <= 16'h0000;
    wr(8'h10, 16'h0000, 2'h0);
    wr(8'h0C, 16'hFFFF, 2'h0);
    wr(8'h08, 16'h00FF, 2'h0);
    settle();
    chk_pad(16'hFF00, 16'h0000);
    rdc(8'h04, 16'h00FF, 2'h0);
    wr(8'h0C, 16'h0000, 2'h0);
  endtask

  // Peripheral drives the low byte; enabled but idle on the next nibble.
  task automatic t_periph();
    wr(8'h08, 16'hAAAA, 2'h0);
    periph <= '{enabled: 16'h0FFF, drive: 16'h00FF, data: 16'h0055};
    settle();
    chk_pad(16'hFFFF, 16'hAA55);
    rdc(8'h04, 16'hAA55 & M, 2'h0);
    chk({16'h0000, periph_rx & 16'h7F00}, 32'h0);
    periph <= '0;
  endtask

  // A second reset in mid-run, with pins driven, must restore all inputs.
  task automatic t_rereset();
    reset_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    chk_pad(16'h0000, 16'h0000);
    rdc(8'h00, 16'hFFFF & M, 2'h0);
    rdc(8'h10, 16'hFFFF & M, 2'h0);
  endtask

  // ==========================================================================
  // Main sequence and verdict
  // ==========================================================================
  task automatic end_of_test();
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reset for three cycles, then run every scenario in turn.
  initial begin
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_latch_pin();
    t_input();
    t_analog_out();
    t_open_drain();
    t_periph();
    t_rereset();
    end_of_test();
  end
endmodule
`default_nettype wire
